// ---- hdl/spm_pkg.sv ----
// Package for the serial port: register map, field layouts, resets, timing.
package spm_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [3:0] OFF_CTRL = 4'h0; // Control
    localparam logic [3:0] OFF_STAT = 4'h4; // Status
    localparam logic [3:0] OFF_DATA = 4'h8; // Data
    localparam logic [3:0] OFF_CFG = 4'hC; // Power and pin setup

    // ****************************************
    // Field layouts
    // ****************************************
    // Control register, bits 7..0
    typedef struct packed {
        logic irq_en; // transfer_irq_enable
        logic enable; // Port enable
        logic lsb_first; // Bit order
        logic master_select; // Master when set
        logic clock_idle_level; // SCK idle level
        logic clock_sample_phase; // Sample on trailing edge when set
        logic [1:0] rate; // Master SCK rate
    } spm_ctrl_t;

    // Power and pin setup register, bits 5..0
    typedef struct packed {
        logic ss_level; // SS level when used as plain output
        logic miso_dir; // Slave: drive MISO
        logic sck_dir; // Master: drive SCK
        logic mosi_dir; // Master: drive MOSI
        logic ss_dir; // Master: SS is an output
        logic spi_power_off; // Port held off while set
    } spm_cfg_t;

    localparam int STAT_DONE = 7; // transfer_done_flag
    localparam int STAT_WCOL = 6; // Write collision flag
    localparam int STAT_DBL = 0; // Double speed

    // ****************************************
    // Reset values
    // ****************************************
    localparam spm_ctrl_t CTRL_RST = 8'h00;
    localparam spm_cfg_t CFG_RST = 6'h01; // Powered off out of reset

    // ****************************************
    // Timing: SCK half period in clocks, by {double, rate}
    // ****************************************
    localparam int BITS = 8; // Bits per byte
    localparam logic [3:0] LAST_EDGE = 4'hF; // Sixteen SCK edges per byte
    localparam logic [6:0] HALF_PER [8] = '{
        7'h02, 7'h08, 7'h20, 7'h40, 7'h01, 7'h04, 7'h10, 7'h20
    };

endpackage

// ---- hdl/spm_port.sv ----
// Byte-wide master/slave serial port with an APB register slave.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps

module spm_port #(
    parameter int ADDR_W = 8 // APB address width
) (
    input wire logic pclk, // APB clock, 125 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error, unmapped address
    input wire logic irq_ack, // Interrupt vector taken
    output logic irq, // Interrupt request
    input wire logic sck_i, // SCK pin level
    output logic sck_o, // SCK drive value
    output logic sck_oe, // SCK drive enable
    input wire logic mosi_i, // MOSI pin level
    output logic mosi_o, // MOSI drive value
    output logic mosi_oe, // MOSI drive enable
    input wire logic miso_i, // MISO pin level
    output logic miso_o, // MISO drive value
    output logic miso_oe, // MISO drive enable
    input wire logic ss_n_i, // SS pin level, active low
    output logic ss_n_o, // SS drive value
    output logic ss_n_oe // SS drive enable
);

    // ****************************************
    // Parameter check
    // ****************************************
    if (ADDR_W < 5) begin : g_bad_addr
        $error("ADDR_W must be at least 5");
    end

    // ****************************************
    // State
    // ****************************************
    spm_pkg::spm_ctrl_t ctrl; // Control register
    spm_pkg::spm_cfg_t cfg; // Power and pin setup
    logic dbl; // Double speed
    logic done_flag; // transfer_done_flag
    logic wcol; // Write collision
    logic clr_arm; // Status read seen with a flag set
    logic [7:0] shreg; // Shift register
    logic [7:0] rx_buf; // Receive buffer
    logic samp; // Bit caught on the sample edge
    logic [3:0] cnt; // SCK edge count in the byte
    logic busy; // Master clock generator running
    logic [6:0] div; // Half period counter
    logic sck_m; // Master SCK level
    logic [3:0] sync1; // First sync stage
    logic [3:0] sync2; // Second sync stage
    logic sck_d; // Delayed synced SCK

    // ****************************************
    // Decode
    // ****************************************
    logic on; // Port enabled and powered
    logic is_master; // Master mode active
    logic is_slave; // Slave mode active
    logic sck_s; // Synced SCK
    logic mosi_s; // Synced MOSI
    logic miso_s; // Synced MISO
    logic ss_s; // Synced SS
    logic acc; // APB access completes now
    logic wr; // Completing write
    logic rd; // Completing read
    logic hit; // Address maps to a register
    logic [1:0] idx; // Register index
    logic edge_ev; // One SCK edge for the shifter
    logic sample_now; // This edge samples
    logic din; // Serial input for this mode
    logic fin; // Byte completes on this edge
    logic [7:0] next_rx; // Completed received byte
    logic mode_fault; // Another master pulled SS low
    logic data_wr; // Data register write
    logic shifting; // A shift cycle is under way

    assign on = ctrl.enable & ~cfg.spi_power_off;
    assign is_master = on & ctrl.master_select;
    assign is_slave = on & ~ctrl.master_select;
    assign sck_s = sync2[0];
    assign mosi_s = sync2[1];
    assign miso_s = sync2[2];
    assign ss_s = sync2[3];
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign hit = (paddr[ADDR_W-1:4] == '0) && (paddr[1:0] == 2'b00);
    assign idx = paddr[3:2];
    assign data_wr = wr & hit & pstrb[0] & (idx == spm_pkg::OFF_DATA[3:2]);
    // Slave counts as shifting while SS is low and its edge count is not zero
    assign shifting = busy | (is_slave & ~ss_s & (cnt != 4'h0));
    // Master edges from the divider; slave edges from synced SCK
    assign edge_ev = is_master ? (busy && div == spm_pkg::HALF_PER[{dbl, ctrl.rate}] - 7'h01)
                               : (is_slave & ~ss_s & (sck_s != sck_d));
    // Even edges lead; phase bit picks which edge samples
    assign sample_now = cnt[0] == ctrl.clock_sample_phase;
    assign din = is_master ? miso_s : mosi_s;
    assign fin = edge_ev & (cnt == spm_pkg::LAST_EDGE);
    assign mode_fault = is_master & ~cfg.ss_dir & ~ss_s;

    // Final byte takes the live bit when the last edge samples
    always_comb begin
        logic bit_in;
        bit_in = ctrl.clock_sample_phase ? din : samp;
        if (ctrl.lsb_first) begin
            next_rx = {bit_in, shreg[7:1]};
        end else begin
            next_rx = {shreg[6:0], bit_in};
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Two stages for every pin; edge detect reads stage two only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 4'hF;
            sync2 <= 4'hF;
            sck_d <= 1'b1;
        end else begin
            sync1 <= {ss_n_i, miso_i, mosi_i, sck_i};
            sync2 <= sync1;
            sck_d <= sync2[0];
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    // One wait state so that pready and prdata come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            prdata <= 32'h0000_0000;
            if (psel & penable & ~pready & ~pwrite & hit) begin
                case (idx)
                    2'd0: prdata[7:0] <= ctrl;
                    2'd1: prdata[7:0] <= {done_flag, wcol, 5'h00, dbl};
                    2'd2: prdata[7:0] <= rx_buf;
                    2'd3: prdata[5:0] <= cfg;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control, setup and speed registers; SS fault drops master
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= spm_pkg::CTRL_RST;
            cfg <= spm_pkg::CFG_RST;
            dbl <= 1'b0;
        end else begin
            if (wr & hit & pstrb[0]) begin
                case (idx)
                    2'd0: ctrl <= pwdata[7:0];
                    2'd1: dbl <= pwdata[spm_pkg::STAT_DBL];
                    2'd3: cfg <= pwdata[5:0];
                    default: ;
                endcase
            end
            if (mode_fault) begin
                ctrl.master_select <= 1'b0;
            end
        end
    end

    // ****************************************
    // Flags
    // ****************************************
    // Clear pair: status read with a flag set, then a data access.
    // Set wins over clear so a byte ending on that edge is not lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
            wcol <= 1'b0;
            clr_arm <= 1'b0;
        end else begin
            if (rd & hit & (idx == spm_pkg::OFF_STAT[3:2]) & (done_flag | wcol)) begin
                clr_arm <= 1'b1;
            end else if (acc & hit & (idx == spm_pkg::OFF_DATA[3:2])) begin
                clr_arm <= 1'b0;
            end
            if (irq_ack | (clr_arm & acc & hit & (idx == spm_pkg::OFF_DATA[3:2]))) begin
                done_flag <= 1'b0;
            end
            if (clr_arm & acc & hit & (idx == spm_pkg::OFF_DATA[3:2])) begin
                wcol <= 1'b0;
            end
            if (fin | mode_fault) begin
                done_flag <= 1'b1;
            end
            if (data_wr & shifting) begin
                wcol <= 1'b1;
            end
        end
    end

    // Interrupt request follows the flag and its enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= done_flag & ctrl.irq_en;
        end
    end

    // ****************************************
    // Master clock generator
    // ****************************************
    // A data write starts sixteen SCK edges, then the clock halts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            div <= 7'h00;
            sck_m <= 1'b0;
        end else begin
            if (!is_master || mode_fault) begin
                busy <= 1'b0;
                div <= 7'h00;
                sck_m <= ctrl.clock_idle_level;
            end else if (!busy) begin
                div <= 7'h00;
                sck_m <= ctrl.clock_idle_level;
                if (data_wr) begin
                    busy <= 1'b1;
                end
            end else if (edge_ev) begin
                div <= 7'h00;
                sck_m <= ~sck_m;
                if (fin) begin
                    busy <= 1'b0;
                end
            end else begin
                div <= div + 7'h01;
            end
        end
    end

    // ****************************************
    // Shifter, shared by both modes
    // ****************************************
    // Sample edges catch a bit, the other edges move it in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg <= 8'h00;
            samp <= 1'b0;
            cnt <= 4'h0;
            rx_buf <= 8'h00;
        end else begin
            if (data_wr && !shifting) begin
                shreg <= pwdata[7:0];
                cnt <= 4'h0;
            end else if (!on || (is_slave && ss_s) || mode_fault) begin
                cnt <= 4'h0;
            end else if (edge_ev) begin
                cnt <= cnt + 4'h1;
                if (fin) begin
                    rx_buf <= next_rx;
                    shreg <= next_rx;
                end else if (sample_now) begin
                    samp <= din;
                end else if (cnt != 4'h0) begin
                    if (ctrl.lsb_first) begin
                        shreg <= {samp, shreg[7:1]};
                    end else begin
                        shreg <= {shreg[6:0], samp};
                    end
                end
            end
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // Enabled port owns pin directions; SS never driven by the shifter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
            mosi_o <= 1'b0;
            mosi_oe <= 1'b0;
            miso_o <= 1'b0;
            miso_oe <= 1'b0;
            ss_n_o <= 1'b1;
            ss_n_oe <= 1'b0;
        end else begin
            sck_o <= sck_m;
            mosi_o <= ctrl.lsb_first ? shreg[0] : shreg[7];
            miso_o <= ctrl.lsb_first ? shreg[0] : shreg[7];
            ss_n_o <= cfg.ss_level;
            sck_oe <= is_master & cfg.sck_dir;
            mosi_oe <= is_master & cfg.mosi_dir;
            ss_n_oe <= is_master & cfg.ss_dir;
            miso_oe <= is_slave & cfg.miso_dir & ~ss_s;
        end
    end

endmodule // spm_port

// ---- tb/spm_monitor.sv ----
// Checker for the serial port: bus handshake, flag clearing and pin drives.
`timescale 1ns/1ps
module spm_monitor #(
    parameter int ADDR_W = 8 // Bus address width
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Write
    input wire logic [ADDR_W-1:0] paddr, // Address
    input wire logic pready, // Ready
    input wire logic [31:0] prdata, // Read data
    input wire logic pslverr, // Error
    input wire logic irq_ack, // Vector taken
    input wire logic irq, // Request
    input wire logic ss_n_i, // SS line
    input wire logic sck_o, // SCK value
    input wire logic sck_oe, // SCK enable
    input wire logic mosi_oe, // MOSI enable
    input wire logic miso_oe, // MISO enable
    input wire logic ss_n_o, // SS value
    input wire logic ss_n_oe // SS enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [4:0] n_tog; // SCK toggles since the flag was last cleared
    logic sck_q; // SCK value, one cycle back
    logic irq_q; // Request, one cycle back
    // ****************************************
    // Helper logic
    // ****************************************
    // Toggle count; restarts when the request drops so each byte counts alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_tog <= 5'h00;
        end else if (irq_q && !irq) begin
            n_tog <= 5'h00; // Flag cleared
        end else if (sck_o != sck_q) begin
            n_tog <= n_tog + 5'h01; // One more edge
        end
    end
    // Delayed copies for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            sck_q <= sck_o;
            irq_q <= irq;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    sequence s_stat_done;
        psel && penable && pready && !pwrite && paddr == spm_pkg::OFF_STAT && prdata[7];
    endsequence
    sequence s_data_acc;
        psel && penable && pready && paddr == spm_pkg::OFF_DATA;
    endsequence
    property p_wait;
        psel && penable && !$past(penable) |-> !pready ##1 pready;
    endproperty
    property p_unmapped;
        psel && penable && pready && (paddr > 8'h0C || paddr[1:0] != 2'h0) |-> pslverr;
    endproperty
    property p_read_pair;
        s_stat_done ##[1:8] s_data_acc |-> ##[1:2] !irq;
    endproperty
    property p_ack;
        irq && irq_ack |-> ##2 !irq;
    endproperty
    property p_eight_bits;
        $rose(irq) && sck_oe |-> ##[1:2] n_tog == 5'h10;
    endproperty
    property p_slave_idle;
        ss_n_i [*4] |-> !miso_oe;
    endproperty
    property p_pin_dir;
        miso_oe |-> !sck_oe && !mosi_oe && !ss_n_oe;
    endproperty
    property p_ss_manual;
        // The pin moves one cycle after the setup write lands
        ss_n_oe && $stable(ss_n_oe) && $changed(ss_n_o) |-> $past(pready, 2) && $past(pwrite, 2);
    endproperty
    a_wait: assert property (p_wait) else $error("ready not after one wait");
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
    a_read_pair: assert property (p_read_pair) else $error("read pair kept flag");
    a_ack: assert property (p_ack) else $error("ack kept request");
    a_eight_bits: assert property (p_eight_bits) else $error("not 16 edges");
    a_slave_idle: assert property (p_slave_idle) else $error("MISO driven, SS high");
    a_pin_dir: assert property (p_pin_dir) else $error("pin override broken");
    a_ss_manual: assert property (p_ss_manual) else $error("SS moved alone");
endmodule // spm_monitor

bind spm_port spm_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq_ack(irq_ack), .irq(irq), .ss_n_i(ss_n_i), .sck_o(sck_o), .sck_oe(sck_oe),
    .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe)
);

// ---- tb/spm_peer.sv ----
// Far-side serial device: slave to the port's master, or master to its slave.
`timescale 1ns/1ps
module spm_peer (
    input wire logic sck, // SCK line
    input wire logic mosi, // MOSI line
    input wire logic miso, // MISO line
    input wire logic ss_n, // SS line
    output logic p_drv, // Peer is master
    output logic p_sck, // SCK drive
    output logic p_mosi, // MOSI drive
    output logic p_ss_n, // SS drive
    output logic p_miso, // MISO drive
    output logic p_miso_oe // MISO enable
);
    logic [7:0] tx; // Byte to answer with as slave
    logic [7:0] rx; // Last byte seen
    logic [7:0] sh; // Slave shift register
    logic seen; // A sample edge has passed since select
    initial begin
        p_drv = 1'b0;
        p_sck = 1'b0;
        p_mosi = 1'b0;
        p_ss_n = 1'b1;
        {tx, rx, sh} = 24'h000000;
        seen = 1'b0;
    end
    // As slave it answers only while selected
    assign p_miso = sh[7];
    assign p_miso_oe = !ss_n && !p_drv;
    // Select loads the answer; its first bit stands before the first edge
    always @(negedge ss_n) begin
        if (!p_drv) begin
            sh = tx;
            seen = 1'b0;
        end
    end
    // Sample on rising edges, shift on falling ones after a sample: modes 0 and 3
    always @(posedge sck) begin
        if (!ss_n) begin
            rx = {rx[6:0], p_drv ? miso : mosi};
            seen = 1'b1;
        end
    end
    always @(negedge sck) if (!ss_n && !p_drv && seen) sh = {sh[6:0], 1'b0};
    // Master role: n bits, slow phases so the port's sampling is safe
    task automatic xfer(input logic [7:0] b, input int n);
        #2 p_drv = 1'b1; // Off the port's clock edge; SCK settles at idle before select
        #80 p_ss_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            p_mosi = b[7 - i];
            #80 p_sck = 1'b1;
            #80 p_sck = 1'b0;
        end
        #80 p_ss_n = 1'b1;
    endtask
    // Hold SS at a level, used to select the port from outside
    task automatic sel(input logic v);
        #2 p_drv = 1'b1; // Off the port's clock edge
        p_ss_n = v;
    endtask
endmodule // spm_peer

// ---- tb/spm_port_test.sv ----
// Self-checking bench for the serial port: registers, master and slave bytes.
`timescale 1ns/1ps
module spm_port_test;
    logic pclk, presetn, psel, penable, pwrite, irq_ack, tgl; // Bench drives
    logic [7:0] paddr; // Byte address
    logic [31:0] pwdata, prdata, r; // Bus data
    logic pready, pslverr, irq, e; // Port answers
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe; // Pins
    logic p_drv, p_sck, p_mosi, p_ss_n, p_miso, p_miso_oe; // Peer drives
    wire sck, mosi, miso, ss_n; // Resolved lines
    int n_errors, compares, cyc;
    // Released lines carry a moving pattern; SS has a pull-up
    assign sck = sck_oe ? sck_o : (p_drv ? p_sck : tgl);
    assign mosi = mosi_oe ? mosi_o : (p_drv ? p_mosi : tgl);
    assign miso = miso_oe ? miso_o : (p_miso_oe ? p_miso : tgl);
    assign ss_n = ss_n_oe ? ss_n_o : (p_drv ? p_ss_n : 1'b1);
    spm_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq_ack(irq_ack), .irq(irq), .sck_i(sck),
        .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
        .miso_i(miso), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n), .ss_n_o(ss_n_o),
        .ss_n_oe(ss_n_oe));
    spm_peer pk (.sck(sck), .mosi(mosi), .miso(miso), .ss_n(ss_n), .p_drv(p_drv),
        .p_sck(p_sck), .p_mosi(p_mosi), .p_ss_n(p_ss_n), .p_miso(p_miso),
        .p_miso_oe(p_miso_oe));
    // ****************************************
    // Clock, pattern and hang guard
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        tgl <= ~tgl;
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_sim;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %0h seen %0h", n, exp, seen);
        end
    endtask
    // One bus transfer: setup, access held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 64) n_errors++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(n, r, {24'h000000, exp});
    endtask
    // Bounded wait for the request
    task automatic wirq;
        int n = 0;
        while (irq !== 1'b1 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        chk("irq", {31'h0, irq}, 32'h1);
    endtask
    task automatic sx(input logic [7:0] b, input int n);
        pk.xfer(b, n);
        @(posedge pclk);
    endtask
    // Master byte framed by SS under software control
    task automatic mbyte(input logic [7:0] tx, input logic [7:0] ptx, input logic [7:0] ep,
        input logic [7:0] ed);
        pk.tx = ptx;
        wr(spm_pkg::OFF_CFG, 8'h2E);
        wr(spm_pkg::OFF_CFG, 8'h0E);
        wr(spm_pkg::OFF_DATA, tx);
        wirq();
        chk("peer_rx", pk.rx, ep);
        rd("status", spm_pkg::OFF_STAT, 8'h80);
        rd("data", spm_pkg::OFF_DATA, ed);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {n_errors, compares, cyc} = 96'h0;
        {presetn, psel, penable, pwrite, irq_ack, tgl} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("ctrl", spm_pkg::OFF_CTRL, 8'h00);
        rd("cfg", spm_pkg::OFF_CFG, 8'h01);
        rd("status", spm_pkg::OFF_STAT, 8'h00);
        rd("unmapped", 8'h10, 8'h00);
        chk("slverr", {31'h0, e}, 32'h1);
        wr(spm_pkg::OFF_CTRL, 8'hD1);
        mbyte(8'hA5, 8'h3C, 8'hA5, 8'h3C);
        // Second write during the shift is refused
        pk.tx = 8'h3C;
        wr(spm_pkg::OFF_CFG, 8'h2E);
        wr(spm_pkg::OFF_CFG, 8'h0E);
        wr(spm_pkg::OFF_DATA, 8'h11);
        wr(spm_pkg::OFF_DATA, 8'h22);
        wirq();
        chk("peer_rx", pk.rx, 8'h11);
        rd("status", spm_pkg::OFF_STAT, 8'hC0);
        // Mode 3, LSB first; idle level moves while the flag still stands
        wr(spm_pkg::OFF_CTRL, 8'hFD);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("irq", {31'h0, irq}, 32'h0);
        mbyte(8'h01, 8'h3A, 8'h80, 8'h5C);
        // Slave: byte loaded while deselected
        wr(spm_pkg::OFF_CTRL, 8'hC0);
        wr(spm_pkg::OFF_CFG, 8'h10);
        wr(spm_pkg::OFF_DATA, 8'h96);
        sx(8'h5B, 8);
        chk("peer_rx", pk.rx, 8'h96);
        wirq();
        wr(spm_pkg::OFF_DATA, 8'hC3);
        rd("data", spm_pkg::OFF_DATA, 8'h5B);
        sx(8'h11, 8);
        chk("peer_rx", pk.rx, 8'hC3);
        sx(8'h33, 4);
        sx(8'h7E, 8);
        rd("data", spm_pkg::OFF_DATA, 8'h7E);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        // Master with SS as input, selected from outside
        wr(spm_pkg::OFF_CTRL, 8'h50);
        wr(spm_pkg::OFF_CFG, 8'h0C);
        pk.sel(1'b0);
        repeat (8) @(posedge pclk);
        rd("ctrl", spm_pkg::OFF_CTRL, 8'h40);
        rd("status", spm_pkg::OFF_STAT, 8'h80);
        end_sim();
    end
endmodule // spm_port_test
